// File: src/sctp_top.sv
// System configuration registers, clock divider, timer prescaler,
// pin sampling and timer overflow pin toggling.
// Assumes one 250 MHz clock, a synchronous active-high reset and a
// register port with read data valid the cycle after the read strobe.
//
// Operation
// - Any reset restores every software bit's default
// - Two mode bits per pin, fuse-set default
// - Reload register sets oscillator to system division
// - Shared prescaler, select in clock register 7:4
// - Compatibility mode select resets to 0101
// - Count rate full clock down to sixteenth
// - Fast mode select resets to 0000
// - Timer 2 clock-out/baud modes bypass prescaler
// - Compatibility mode samples pins at prescaler rate
// - Fast mode samples pins every system clock
// - Timer overflow toggles own pin when enabled
// - Auxiliary A bit 0 controls latch strobe
// - Auxiliary A bit 1 gates on-chip xdata
// - Fuse sets on-chip xdata access default
// - Auxiliary A bits 6:5 set wait states
// - Auxiliary B bit 4 places stack
// - EEPROM control bit 1 gates EEPROM access
// - Auxiliary B bit 5 gates flash API
// - Fuse sets clock doubling default
// - Fuse picks compatible or fast execution
// - Fuse picks start-up time-out delay
// - Fuse picks primary clock source
// - Default prescale divisor six or one
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "sctp_defines.svh"

module sctp_top #(
    parameter int NUM_PORTS = 5,
    parameter int PINS_PER_PORT = 8
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [7:0] REG_RDATA_OUT,
    input wire sctp_pkg::sctp_fuse_t FUSE_IN,
    input wire sctp_pkg::sctp_pins_t EXT_PINS_IN,
    input wire logic T2_BYPASS_MODE_IN,
    input wire logic T0_OVERFLOW_IN,
    input wire logic T1_OVERFLOW_IN,
    output logic SYS_CLK_EN_OUT,
    output logic TIMER_TICK_OUT,
    output logic T2_TICK_OUT,
    output sctp_pkg::sctp_pins_t SAMPLED_PINS_OUT,
    output logic T0_PIN_OUT,
    output logic T1_PIN_OUT,
    output logic [1:0] CLK_SOURCE_OUT,
    output logic [1:0] STARTUP_DELAY_OUT,
    output logic FAST_MODE_OUT,
    output logic ADDR_LATCH_STROBE_CTL_OUT,
    output logic ONCHIP_XDATA_ENABLE_OUT,
    output logic [1:0] XDATA_WAIT_STATES_OUT,
    output logic STACK_IN_EXTRA_RAM_OUT,
    output logic EEPROM_ACCESS_ENABLE_OUT,
    output logic FLASH_API_ENABLE_OUT,
    output logic [NUM_PORTS*PINS_PER_PORT-1:0] PORT_MODE_LOW_BIT_OUT,
    output logic [NUM_PORTS*PINS_PER_PORT-1:0] PORT_MODE_HIGH_BIT_OUT
);

    localparam int NPINS = NUM_PORTS * PINS_PER_PORT;

    // Oscillator clocks per system clock, minus one
    function automatic logic [8:0] div_limit(input logic [7:0] reload,
                                             input logic doubled);
        logic [8:0] base;
        base = {1'b0, 8'hff - reload};
        div_limit = doubled ? base : {base[7:0], 1'b1};
    endfunction

    // Reset mode of one pin from fuse and port number
    function automatic logic [1:0] pin_default(input logic tristate,
                                               input int port);
        if (tristate) begin
            pin_default = sctp_pkg::SCTP_PM_INPUT_ONLY;
        end else if (port == 0) begin
            pin_default = sctp_pkg::SCTP_PM_OPEN_DRAIN;
        end else begin
            pin_default = sctp_pkg::SCTP_PM_QUASI;
        end
    endfunction

    // Fuse and pin synchronisers
    sctp_pkg::sctp_fuse_t fuse_s1;
    sctp_pkg::sctp_fuse_t fuse_s2;
    sctp_pkg::sctp_fuse_t fuse_s3;
    sctp_pkg::sctp_pins_t pin_s1;
    sctp_pkg::sctp_pins_t pin_s2;
    sctp_pkg::sctp_pins_t pin_s3;

    always_ff @(posedge CORE_CLK_IN) begin
        fuse_s1 <= FUSE_IN;
        fuse_s2 <= fuse_s1;
        fuse_s3 <= fuse_s2;
        pin_s1 <= EXT_PINS_IN;
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
    end

    // Fuse values latched while reset is held
    sctp_pkg::sctp_fuse_t fuse;

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            fuse <= fuse_s3;
        end
    end

    // Software registers
    logic [7:0] osc_reload;
    logic [3:0] timer_prescale_select;
    logic clock_doubling_choice;
    logic addr_latch_strobe_ctl;
    logic onchip_xdata_enable;
    logic [1:0] xdata_wait_states;
    logic stack_in_extra_ram;
    logic flash_api_enable;
    logic eeprom_access_enable;
    logic [1:0] toggle_en;
    logic [NPINS-1:0] port_mode_low_bit;
    logic [NPINS-1:0] port_mode_high_bit;

    wire wr_aux_a = REG_WR_IN && (REG_ADDR_IN == `SCTP_ADDR_AUX_A);
    wire wr_aux_b = REG_WR_IN && (REG_ADDR_IN == `SCTP_ADDR_AUX_B);
    wire wr_clk_ctrl = REG_WR_IN && (REG_ADDR_IN == `SCTP_ADDR_CLK_CTRL);
    wire wr_timer_ext = REG_WR_IN && (REG_ADDR_IN == `SCTP_ADDR_TIMER_EXT);
    wire wr_reload = REG_WR_IN && (REG_ADDR_IN == `SCTP_ADDR_OSC_RELOAD);
    wire wr_clk_setup = REG_WR_IN && (REG_ADDR_IN == `SCTP_ADDR_CLK_SETUP);
    wire wr_eeprom = REG_WR_IN && (REG_ADDR_IN == `SCTP_ADDR_EEPROM_CTRL);
    wire in_port_range = (REG_ADDR_IN >= `SCTP_ADDR_PORT_MODE_BASE) &&
                         (REG_ADDR_IN <= `SCTP_ADDR_PORT_MODE_LAST);
    wire [7:0] port_off = REG_ADDR_IN - `SCTP_ADDR_PORT_MODE_BASE;
    wire [6:0] port_sel = port_off[7:1];
    wire port_high = port_off[0];
    wire wr_port = REG_WR_IN && in_port_range;

    // Reset defaults that depend on the execution mode fuse
    wire [3:0] tps_default = fuse.compat_mode ? `SCTP_RST_TPS_COMPAT
                                              : `SCTP_RST_TPS_FAST;

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            timer_prescale_select <= tps_default;
        end else if (wr_clk_setup) begin
            timer_prescale_select <= REG_WDATA_IN[`SCTP_BIT_TPS_HI:`SCTP_BIT_TPS_LO];
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            osc_reload <= `SCTP_RST_OSC_RELOAD;
        end else if (wr_reload) begin
            osc_reload <= REG_WDATA_IN;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            clock_doubling_choice <= fuse.clock_doubling_choice;
        end else if (wr_clk_ctrl) begin
            clock_doubling_choice <= REG_WDATA_IN[`SCTP_BIT_DOUBLING];
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            addr_latch_strobe_ctl <= 1'b0;
            onchip_xdata_enable <= fuse.xdata_default_en;
            xdata_wait_states <= `SCTP_RST_WAIT_STATES;
        end else if (wr_aux_a) begin
            addr_latch_strobe_ctl <= REG_WDATA_IN[`SCTP_BIT_ALE_CTL];
            onchip_xdata_enable <= REG_WDATA_IN[`SCTP_BIT_XDATA_EN];
            xdata_wait_states <=
                REG_WDATA_IN[`SCTP_BIT_WS_HI:`SCTP_BIT_WS_LO];
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            stack_in_extra_ram <= 1'b0;
            flash_api_enable <= 1'b0;
        end else if (wr_aux_b) begin
            stack_in_extra_ram <= REG_WDATA_IN[`SCTP_BIT_STACK_XRAM];
            flash_api_enable <= REG_WDATA_IN[`SCTP_BIT_FLASH_API];
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            eeprom_access_enable <= 1'b0;
        end else if (wr_eeprom) begin
            eeprom_access_enable <= REG_WDATA_IN[`SCTP_BIT_EEPROM_EN];
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            toggle_en <= 2'h0;
        end else if (wr_timer_ext) begin
            toggle_en <= {REG_WDATA_IN[`SCTP_BIT_T1_TOGGLE],
                          REG_WDATA_IN[`SCTP_BIT_T0_TOGGLE]};
        end
    end

    // Port mode bits, one byte per port per mode bit
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
            wire [1:0] dflt = pin_default(fuse.port_tristate, gp);
            wire hit = wr_port && (port_sel == 7'(gp));
            always_ff @(posedge CORE_CLK_IN) begin
                if (RST_IN) begin
                    port_mode_low_bit[gp*PINS_PER_PORT +: PINS_PER_PORT] <=
                        {PINS_PER_PORT{dflt[0]}};
                    port_mode_high_bit[gp*PINS_PER_PORT +: PINS_PER_PORT] <=
                        {PINS_PER_PORT{dflt[1]}};
                end else if (hit && !port_high) begin
                    port_mode_low_bit[gp*PINS_PER_PORT +: PINS_PER_PORT] <=
                        REG_WDATA_IN[PINS_PER_PORT-1:0];
                end else if (hit && port_high) begin
                    port_mode_high_bit[gp*PINS_PER_PORT +: PINS_PER_PORT] <=
                        REG_WDATA_IN[PINS_PER_PORT-1:0];
                end
            end
        end
    endgenerate

    // Oscillator to system clock divider
    logic [8:0] div_cnt;
    logic sys_en;
    wire [8:0] limit = div_limit(osc_reload, clock_doubling_choice);
    wire div_wrap = (div_cnt >= limit);

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            div_cnt <= 9'h000;
            sys_en <= 1'b0;
        end else begin
            div_cnt <= div_wrap ? 9'h000 : div_cnt + 9'h001;
            sys_en <= div_wrap;
        end
    end

    // Shared timer prescaler
    logic [3:0] ps_cnt;
    wire ps_wrap = (ps_cnt >= timer_prescale_select);
    wire next_tick = sys_en && ps_wrap;
    wire next_t2_tick = T2_BYPASS_MODE_IN ? sys_en : next_tick;

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            ps_cnt <= 4'h0;
        end else if (sys_en) begin
            ps_cnt <= ps_wrap ? 4'h0 : ps_cnt + 4'h1;
        end
    end

    // Pin sampling rate follows execution mode
    wire sample_en = fuse.compat_mode ? next_tick
                                      : sys_en;
    wire [5:0] pin_agree = ~(pin_s2 ^ pin_s3);
    wire [5:0] next_pins = (pin_agree & pin_s3) |
                           (~pin_agree & SAMPLED_PINS_OUT);

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            SAMPLED_PINS_OUT <= '0;
        end else if (sample_en) begin
            SAMPLED_PINS_OUT <= next_pins;
        end
    end

    // Overflow pin toggling
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            T0_PIN_OUT <= 1'b0;
            T1_PIN_OUT <= 1'b0;
        end else begin
            T0_PIN_OUT <= T0_PIN_OUT ^ (T0_OVERFLOW_IN & toggle_en[0]);
            T1_PIN_OUT <= T1_PIN_OUT ^ (T1_OVERFLOW_IN & toggle_en[1]);
        end
    end

    // Read decode
    wire [7:0] rd_aux_a = {1'b0, xdata_wait_states, 3'h0,
                           onchip_xdata_enable, addr_latch_strobe_ctl};
    wire [7:0] rd_aux_b = {2'h0, flash_api_enable, stack_in_extra_ram, 4'h0};
    wire [7:0] rd_port = port_high
        ? 8'(port_mode_high_bit[port_sel*PINS_PER_PORT +: PINS_PER_PORT])
        : 8'(port_mode_low_bit[port_sel*PINS_PER_PORT +: PINS_PER_PORT]);
    wire [7:0] rd_mux =
        (REG_ADDR_IN == `SCTP_ADDR_AUX_A) ? rd_aux_a :
        (REG_ADDR_IN == `SCTP_ADDR_AUX_B) ? rd_aux_b :
        (REG_ADDR_IN == `SCTP_ADDR_CLK_CTRL) ?
            {7'h00, clock_doubling_choice} :
        (REG_ADDR_IN == `SCTP_ADDR_TIMER_EXT) ? {6'h00, toggle_en} :
        (REG_ADDR_IN == `SCTP_ADDR_OSC_RELOAD) ? osc_reload :
        (REG_ADDR_IN == `SCTP_ADDR_CLK_SETUP) ? {timer_prescale_select, 4'h0} :
        (REG_ADDR_IN == `SCTP_ADDR_EEPROM_CTRL) ?
            {6'h00, eeprom_access_enable, 1'b0} :
        in_port_range ? rd_port : 8'h00;

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            REG_RDATA_OUT <= 8'h00;
        end else begin
            REG_RDATA_OUT <= REG_RD_IN ? rd_mux : 8'h00;
        end
    end

    // Registered outputs
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            SYS_CLK_EN_OUT <= 1'b0;
            TIMER_TICK_OUT <= 1'b0;
            T2_TICK_OUT <= 1'b0;
        end else begin
            SYS_CLK_EN_OUT <= sys_en;
            TIMER_TICK_OUT <= next_tick;
            T2_TICK_OUT <= next_t2_tick;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        CLK_SOURCE_OUT <= fuse.clk_source;
        STARTUP_DELAY_OUT <= fuse.startup_delay;
        FAST_MODE_OUT <= ~fuse.compat_mode;
        ADDR_LATCH_STROBE_CTL_OUT <= addr_latch_strobe_ctl;
        ONCHIP_XDATA_ENABLE_OUT <= onchip_xdata_enable;
        XDATA_WAIT_STATES_OUT <= xdata_wait_states;
        STACK_IN_EXTRA_RAM_OUT <= stack_in_extra_ram;
        EEPROM_ACCESS_ENABLE_OUT <= eeprom_access_enable;
        FLASH_API_ENABLE_OUT <= flash_api_enable;
        PORT_MODE_LOW_BIT_OUT <= port_mode_low_bit;
        PORT_MODE_HIGH_BIT_OUT <= port_mode_high_bit;
    end

endmodule

// File: src/sctp_defines.svh
// Register offsets, field positions, reset values for the system config block.
// Assumes an 8-bit register address space reached over a plain port.
`ifndef SCTP_DEFINES_SVH
`define SCTP_DEFINES_SVH

`define SCTP_ADDR_AUX_A 8'h8e
`define SCTP_ADDR_CLK_CTRL 8'h8f
`define SCTP_ADDR_TIMER_EXT 8'h91
`define SCTP_ADDR_OSC_RELOAD 8'h97
`define SCTP_ADDR_AUX_B 8'ha2
`define SCTP_ADDR_CLK_SETUP 8'hae
`define SCTP_ADDR_PORT_MODE_BASE 8'hc0
`define SCTP_ADDR_PORT_MODE_LAST 8'hc9
`define SCTP_ADDR_EEPROM_CTRL 8'hd2

`define SCTP_BIT_ALE_CTL 0
`define SCTP_BIT_XDATA_EN 1
`define SCTP_BIT_WS_LO 5
`define SCTP_BIT_WS_HI 6
`define SCTP_BIT_STACK_XRAM 4
`define SCTP_BIT_FLASH_API 5
`define SCTP_BIT_EEPROM_EN 1
`define SCTP_BIT_TPS_LO 4
`define SCTP_BIT_TPS_HI 7
`define SCTP_BIT_DOUBLING 0
`define SCTP_BIT_T0_TOGGLE 0
`define SCTP_BIT_T1_TOGGLE 1

`define SCTP_RST_TPS_COMPAT 4'h5
`define SCTP_RST_TPS_FAST 4'h0
`define SCTP_RST_OSC_RELOAD 8'hff
`define SCTP_RST_WAIT_STATES 2'h0
`define SCTP_SYNC_STAGES 3

`endif

// File: src/sctp_pkg.sv
// Types shared by the system config and timer prescaler block.
// Assumes the constants header is included where numbers are needed.
package sctp_pkg;

    // Port pin mode, {high bit, low bit}
    typedef enum logic [1:0] {
        SCTP_PM_QUASI = 2'h0,
        SCTP_PM_PUSH_PULL = 2'h1,
        SCTP_PM_INPUT_ONLY = 2'h2,
        SCTP_PM_OPEN_DRAIN = 2'h3
    } sctp_port_mode_t;

    // Nonvolatile options, static while the device runs
    typedef struct packed {
        logic [1:0] clk_source;
        logic clock_doubling_choice;
        logic [1:0] startup_delay;
        logic compat_mode;
        logic xdata_default_en;
        logic port_tristate;
    } sctp_fuse_t;

    // External timer and interrupt pins
    typedef struct packed {
        logic t0;
        logic t1;
        logic t2;
        logic timer2_capture_input;
        logic external_irq_a;
        logic external_irq_b;
    } sctp_pins_t;

endpackage

// File: bench/sctp_checker.sv
// Port-level checks for the system config and timer prescaler block.
// Assumes it is bound onto sctp_top and sees only that module's ports.
`timescale 1ns/10ps
`include "sctp_defines.svh"
module sctp_checker (
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    input wire logic T0_OVERFLOW_IN,
    input wire logic T1_OVERFLOW_IN,
    input wire logic SYS_CLK_EN_OUT,
    input wire logic TIMER_TICK_OUT,
    input wire sctp_pkg::sctp_pins_t SAMPLED_PINS_OUT,
    input wire logic T0_PIN_OUT,
    input wire logic T1_PIN_OUT,
    input wire logic FAST_MODE_OUT,
    input wire logic ADDR_LATCH_STROBE_CTL_OUT,
    input wire logic [1:0] XDATA_WAIT_STATES_OUT
);
    default clocking @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    rdata_idle_a: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property ((REG_RD_IN && REG_ADDR_IN == 8'h90)
        |=> REG_RDATA_OUT == 8'h00)
        else $error("unmapped address read not zero");
    tick_follows_a: assert property (TIMER_TICK_OUT
        |-> SYS_CLK_EN_OUT)
        else $error("tick without a system enable beside it");
    t0_toggle_a: assert property ($changed(T0_PIN_OUT) |-> $past(T0_OVERFLOW_IN))
        else $error("timer 0 pin changed without overflow");
    t1_toggle_a: assert property ($changed(T1_PIN_OUT) |-> $past(T1_OVERFLOW_IN))
        else $error("timer 1 pin changed without overflow");
    compat_sample_a: assert property (($changed(SAMPLED_PINS_OUT) && !FAST_MODE_OUT)
        |-> TIMER_TICK_OUT)
        else $error("pin sample taken away from a tick");
    latch_strobe_a: assert property ((REG_WR_IN && REG_ADDR_IN == `SCTP_ADDR_AUX_A)
        |-> ##2 ADDR_LATCH_STROBE_CTL_OUT == $past(REG_WDATA_IN[0], 2))
        else $error("latch strobe control not following write");
    wait_state_a: assert property ((REG_WR_IN && REG_ADDR_IN == `SCTP_ADDR_AUX_A)
        |-> ##2 XDATA_WAIT_STATES_OUT == $past(REG_WDATA_IN[6:5], 2))
        else $error("wait states not following write");
endmodule

bind sctp_top sctp_checker u_chk (
    .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
    .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
    .T0_OVERFLOW_IN(T0_OVERFLOW_IN), .T1_OVERFLOW_IN(T1_OVERFLOW_IN),
    .SYS_CLK_EN_OUT(SYS_CLK_EN_OUT), .TIMER_TICK_OUT(TIMER_TICK_OUT),
    .SAMPLED_PINS_OUT(SAMPLED_PINS_OUT), .T0_PIN_OUT(T0_PIN_OUT),
    .T1_PIN_OUT(T1_PIN_OUT), .FAST_MODE_OUT(FAST_MODE_OUT),
    .ADDR_LATCH_STROBE_CTL_OUT(ADDR_LATCH_STROBE_CTL_OUT),
    .XDATA_WAIT_STATES_OUT(XDATA_WAIT_STATES_OUT)
);

// File: bench/system_config_timer_prescaler_bench.sv
// Self-checking bench for the system config and timer prescaler block.
// Assumes the checker binds itself; the bench drives every input.
`timescale 1ns/10ps
`include "sctp_defines.svh"
module system_config_timer_prescaler_bench;
    logic clk, rst, wr, rd, byp, ov0, ov1;
    logic [7:0] addr, wdata, rdata;
    logic sys_en, tick, t2_tick, t0p, t1p, fast, ale, xen, stk, eee, fapi;
    logic [1:0] csrc, sdly, ws;
    logic [39:0] pml, pmh;
    sctp_pkg::sctp_fuse_t fuse;
    sctp_pkg::sctp_pins_t pins, spins;
    int n_errors, total_checks, n;

    sctp_top dut (
        .CORE_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_RDATA_OUT(rdata), .FUSE_IN(fuse), .EXT_PINS_IN(pins),
        .T2_BYPASS_MODE_IN(byp), .T0_OVERFLOW_IN(ov0),
        .T1_OVERFLOW_IN(ov1), .SYS_CLK_EN_OUT(sys_en),
        .TIMER_TICK_OUT(tick), .T2_TICK_OUT(t2_tick),
        .SAMPLED_PINS_OUT(spins), .T0_PIN_OUT(t0p), .T1_PIN_OUT(t1p),
        .CLK_SOURCE_OUT(csrc), .STARTUP_DELAY_OUT(sdly),
        .FAST_MODE_OUT(fast), .ADDR_LATCH_STROBE_CTL_OUT(ale),
        .ONCHIP_XDATA_ENABLE_OUT(xen), .XDATA_WAIT_STATES_OUT(ws),
        .STACK_IN_EXTRA_RAM_OUT(stk), .EEPROM_ACCESS_ENABLE_OUT(eee),
        .FLASH_API_ENABLE_OUT(fapi), .PORT_MODE_LOW_BIT_OUT(pml),
        .PORT_MODE_HIGH_BIT_OUT(pmh)
    );

    task automatic end_sim;
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [39:0] e,
                       input logic [39:0] s);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("register %h", a), {32'h0, e}, {32'h0, rdata});
    endtask

    function automatic logic pick(input int w);
        return w == 0 ? sys_en : (w == 1 ? tick : t2_tick);
    endfunction

    // Cycles until the chosen pulse is next seen high
    task automatic gap(input int w, output int c);
        @(posedge clk);
        #1;
        c = 1;
        while (pick(w) !== 1'b1 && c < 200) begin
            @(posedge clk);
            #1;
            c++;
        end
    endtask

    // First gap syncs, second absorbs any wrap, third is measured
    task automatic period(input string what, input int w, input int e);
        int c;
        gap(w, c);
        gap(w, c);
        gap(w, c);
        chk(what, e, c);
    endtask

    task automatic do_reset(input logic [7:0] f);
        @(posedge clk);
        rst <= 1'b1;
        fuse <= sctp_pkg::sctp_fuse_t'(f);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic wait_pins(input logic [5:0] e, input int lim);
        int c;
        c = 0;
        while (spins !== e && c < lim) begin
            @(posedge clk);
            #1;
            c++;
        end
        chk("sampled pins", e, spins);
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #60000;
        n_errors++;
        end_sim();
    end

    initial begin
        rst = 1'b1;
        {wr, rd, byp, ov0, ov1} = 5'h00;
        addr = 8'h00;
        wdata = 8'h00;
        pins = 6'h00;
        n_errors = 0;
        total_checks = 0;
        // Compatibility, tristate ports, xdata on, divide by two
        fuse = sctp_pkg::sctp_fuse_t'(8'h8f);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`SCTP_ADDR_CLK_SETUP, 8'h50);
        rd_chk(`SCTP_ADDR_OSC_RELOAD, 8'hff);
        rd_chk(`SCTP_ADDR_AUX_A, 8'h02);
        rd_chk(`SCTP_ADDR_CLK_CTRL, 8'h00);
        rd_chk(`SCTP_ADDR_AUX_B, 8'h00);
        rd_chk(`SCTP_ADDR_EEPROM_CTRL, 8'h00);
        for (int p = 0; p < 5; p++) begin
            rd_chk(8'(8'hc0 + 2 * p), 8'h00);
            rd_chk(8'(8'hc1 + 2 * p), 8'hff);
        end
        chk("fast mode", 1'b0, fast);
        chk("clock source", 2'h2, csrc);
        chk("startup delay", 2'h1, sdly);
        chk("xdata enable", 1'b1, xen);
        chk("mode high", {40{1'b1}}, pmh);
        chk("mode low", 40'h0, pml);
        period("system enable", 0, 2);
        period("tick", 1, 12);
        period("t2 tick", 2, 12);
        byp <= 1'b1;
        period("t2 bypass tick", 2, 2);
        byp <= 1'b0;
        wr_reg(`SCTP_ADDR_CLK_SETUP, 8'hf0);
        period("tick slowest", 1, 32);
        @(posedge clk);
        pins <= 6'h2a;
        repeat (12) @(posedge clk);
        #1;
        chk("pins before tick", 6'h00, spins);
        wait_pins(6'h2a, 48);
        wr_reg(`SCTP_ADDR_OSC_RELOAD, 8'hfe);
        wr_reg(`SCTP_ADDR_CLK_CTRL, 8'h01);
        period("system enable fe", 0, 2);
        for (int s = 0; s < 16; s += 5) begin
            wr_reg(`SCTP_ADDR_CLK_SETUP, 8'(s << 4));
            rd_chk(`SCTP_ADDR_CLK_SETUP, 8'(s << 4));
            period("tick select", 1, 2 * (s + 1));
        end
        wr_reg(`SCTP_ADDR_OSC_RELOAD, 8'hfc);
        period("system enable fc", 0, 4);
        wr_reg(`SCTP_ADDR_CLK_CTRL, 8'h00);
        period("system enable halved", 0, 8);
        wr_reg(`SCTP_ADDR_AUX_A, 8'hff);
        rd_chk(`SCTP_ADDR_AUX_A, 8'h63);
        wr_reg(`SCTP_ADDR_AUX_B, 8'hff);
        rd_chk(`SCTP_ADDR_AUX_B, 8'h30);
        wr_reg(`SCTP_ADDR_EEPROM_CTRL, 8'hff);
        rd_chk(`SCTP_ADDR_EEPROM_CTRL, 8'h02);
        wr_reg(8'h90, 8'hff);
        rd_chk(8'h90, 8'h00);
        chk("aux outputs", 6'h3f, {ale, xen, ws, stk, fapi});
        chk("eeprom enable", 1'b1, eee);
        wr_reg(`SCTP_ADDR_AUX_A, 8'h20);
        repeat (2) @(posedge clk);
        #1;
        chk("aux a outputs", 4'h1, {ale, xen, ws});
        for (int k = 1; k < 3; k++) begin
            wr_reg(`SCTP_ADDR_TIMER_EXT, 8'(k));
            @(posedge clk);
            ov0 <= 1'b1;
            ov1 <= 1'b1;
            @(posedge clk);
            ov0 <= 1'b0;
            ov1 <= 1'b0;
            #1;
            chk("toggle pins", 2'h2 | 2'(k - 1), {t0p, t1p});
        end
        // Fast mode, default ports, undivided clock
        do_reset(8'h70);
        rd_chk(`SCTP_ADDR_CLK_SETUP, 8'h00);
        rd_chk(`SCTP_ADDR_AUX_A, 8'h00);
        rd_chk(`SCTP_ADDR_TIMER_EXT, 8'h00);
        rd_chk(`SCTP_ADDR_CLK_CTRL, 8'h01);
        rd_chk(`SCTP_ADDR_OSC_RELOAD, 8'hff);
        rd_chk(`SCTP_ADDR_PORT_MODE_BASE, 8'hff);
        rd_chk(8'hc3, 8'h00);
        chk("fast mode", 1'b1, fast);
        chk("toggle pins", 2'h0, {t0p, t1p});
        chk("mode high", 40'hff, pmh);
        period("system enable", 0, 1);
        period("tick", 1, 1);
        @(posedge clk);
        pins <= 6'h15;
        wait_pins(6'h15, 8);
        end_sim();
    end
endmodule
